/* verilog/sbc_exec_defs.vh */
`ifndef SBC_EXEC_DEFS_VH
`define SBC_EXEC_DEFS_VH

// ------------------------------------------------------------
// Operation codes
// ------------------------------------------------------------
`define SBC_OP_PUSH_RP   4'h0
`define SBC_OP_POP_PSW   4'h1
`define SBC_OP_POP_RP    4'h2
`define SBC_OP_JMP_REL   4'h3
`define SBC_OP_JMP_ACC   4'h4
`define SBC_OP_JMP_CY    4'h5
`define SBC_OP_JMP_NCY   4'h6
`define SBC_OP_JMP_Z     4'h7
`define SBC_OP_JMP_NZ    4'h8
`define SBC_OP_BIT_SET   4'h9
`define SBC_OP_BIT_CLR   4'ha
`define SBC_OP_BIT_TCLR  4'hb
`define SBC_OP_DJNZ_REG  4'hc
`define SBC_OP_DJNZ_MEM  4'hd
`define SBC_OP_INT_EN    4'he
`define SBC_OP_INT_DIS   4'hf

// ------------------------------------------------------------
// Bit operand kinds
// ------------------------------------------------------------
`define SBC_KIND_SADDR   3'h0
`define SBC_KIND_SFR     3'h1
`define SBC_KIND_ACC     3'h2
`define SBC_KIND_PSW     3'h3
`define SBC_KIND_PTR     3'h4

// ------------------------------------------------------------
// Status word fields and register indices
// ------------------------------------------------------------
`define SBC_PSW_IE       3'h7
`define SBC_PSW_Z        3'h6
`define SBC_PSW_AC       3'h4
`define SBC_PSW_CY       3'h0
`define SBC_PSW_RESET    8'h02
`define SBC_SP_RESET     16'h0000
`define SBC_PC_RESET     16'h0000
`define SBC_REG_X        3'h0
`define SBC_REG_A        3'h1
`define SBC_REG_C        3'h2
`define SBC_REG_B        3'h3
`define SBC_REG_L        3'h6
`define SBC_REG_H        3'h7
`define SBC_LOAD_PSW     4'h8
`define SBC_LOAD_SPL     4'h9
`define SBC_LOAD_SPH     4'ha
`define SBC_LOAD_PCL     4'hb
`define SBC_LOAD_PCH     4'hc

`endif

/* verilog/sbc_exec.v */
`timescale 1ns/1ns
`default_nettype none
`include "sbc_exec_defs.vh"

module sbc_exec #(
  parameter [15:0] HSRAM_LO = 16'hfb00,  // First byte of internal high-speed RAM.
  parameter [15:0] HSRAM_HI = 16'hfeff   // Last byte of internal high-speed RAM.
) (
  // Clock and reset.
  input  wire        CLK,
  input  wire        ARST_N,
  // CPU clock selection: tick every 2**sel system clocks, sel 0..4.
  input  wire [2:0]  CPU_CLOCK_CTRL_REG,
  // Instruction request.
  input  wire        START,
  input  wire [3:0]  OP,
  input  wire [2:0]  KIND,
  input  wire [2:0]  BIT_SEL,
  input  wire [1:0]  PAIR_SEL,
  input  wire        LOOP_SEL_B,
  input  wire [7:0]  REL_DISP8,
  input  wire [15:0] OPND_ADDR,
  // State load port, used only while idle.
  input  wire        LOAD_EN,
  input  wire [3:0]  LOAD_SEL,
  input  wire [7:0]  LOAD_DATA,
  // Memory port.
  output reg         MEM_RD,
  output reg         MEM_WR,
  output reg  [15:0] MEM_ADDR,
  output reg  [7:0]  MEM_WDATA,
  input  wire [7:0]  MEM_RDATA,
  // Status and architectural state.
  output reg         BUSY,
  output reg         DONE,
  output reg         TAKEN,
  output reg  [15:0] PC,
  output reg  [15:0] SP,
  output reg  [7:0]  STATUS_WORD,
  output reg  [63:0] REGS
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  reg        rst_meta;  // First stage of the reset release.
  reg        rst_n;     // Released reset used by the design.

  // Reset asserts at once and releases after two clock edges.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // CPU clock divider
  // ------------------------------------------------------------
  reg  [3:0] div_cnt;   // Free-running divider count.
  reg  [3:0] div_mask;  // Bits that must all be one for a tick.
  wire       cpu_tick;  // One-cycle enable per CPU clock period.

  // The selection is limited to divide by sixteen.
  always @* begin
    case (CPU_CLOCK_CTRL_REG)
      3'h0:    div_mask = 4'h0;
      3'h1:    div_mask = 4'h1;
      3'h2:    div_mask = 4'h3;
      3'h3:    div_mask = 4'h7;
      default: div_mask = 4'hf;
    endcase
  end

  assign cpu_tick = ((div_cnt & div_mask) == div_mask);

  // The divider counts system clocks.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Cycle count and length tables
  // ------------------------------------------------------------
  // Number of CPU cycles for an operation; far selects the long count.
  function [3:0] cyc_count;
    input [3:0] op;
    input [2:0] kind;
    input       far;
    begin
      case (op)
        `SBC_OP_PUSH_RP, `SBC_OP_POP_RP: cyc_count = 4'h4;
        `SBC_OP_POP_PSW: cyc_count = 4'h2;
        `SBC_OP_JMP_ACC: cyc_count = 4'h8;
        `SBC_OP_DJNZ_MEM: cyc_count = far ? 4'ha : 4'h8;
        `SBC_OP_BIT_SET: begin
          case (kind)
            `SBC_KIND_SADDR: cyc_count = far ? 4'h9 : 4'h8;
            `SBC_KIND_SFR:   cyc_count = 4'hb;
            `SBC_KIND_ACC:   cyc_count = 4'h8;
            `SBC_KIND_PSW:   cyc_count = 4'h9;
            default:         cyc_count = far ? 4'hb : 4'ha;
          endcase
        end
        `SBC_OP_BIT_CLR: begin
          case (kind)
            `SBC_KIND_ACC:   cyc_count = 4'h8;
            `SBC_KIND_SFR, `SBC_KIND_PSW: cyc_count = 4'hb;
            default:         cyc_count = far ? 4'hb : 4'ha;
          endcase
        end
        `SBC_OP_BIT_TCLR: begin
          case (kind)
            `SBC_KIND_ACC:   cyc_count = 4'h8;
            `SBC_KIND_SFR, `SBC_KIND_PSW: cyc_count = 4'hc;
            default:         cyc_count = far ? 4'hc : 4'ha;
          endcase
        end
        default: cyc_count = 4'h6;
      endcase
    end
  endfunction

  // Instruction length in bytes, the base of relative targets.
  function [2:0] op_len;
    input [3:0] op;
    input [2:0] kind;
    begin
      case (op)
        `SBC_OP_PUSH_RP, `SBC_OP_POP_PSW, `SBC_OP_POP_RP: op_len = 3'h1;
        `SBC_OP_DJNZ_MEM: op_len = 3'h3;
        `SBC_OP_BIT_SET:  op_len = (kind == `SBC_KIND_SFR) ? 3'h4 : 3'h3;
        `SBC_OP_BIT_CLR, `SBC_OP_BIT_TCLR: begin
          if (kind == `SBC_KIND_SFR || kind == `SBC_KIND_SADDR || kind == `SBC_KIND_PSW) begin
            op_len = 3'h4;
          end else begin
            op_len = 3'h3;
          end
        end
        default: op_len = 3'h2;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  wire [15:0] ptr_addr  = {REGS[8*`SBC_REG_H +: 8], REGS[8*`SBC_REG_L +: 8]};
  wire        bit_op    = (OP == `SBC_OP_BIT_SET) || (OP == `SBC_OP_BIT_CLR) || (OP == `SBC_OP_BIT_TCLR);
  wire        mem_kind  = (KIND == `SBC_KIND_SADDR) || (KIND == `SBC_KIND_SFR) || (KIND == `SBC_KIND_PTR);
  wire        uses_mem  = (bit_op && mem_kind) || (OP == `SBC_OP_DJNZ_MEM);
  wire [15:0] eff_addr  = (bit_op && KIND == `SBC_KIND_PTR) ? ptr_addr : OPND_ADDR;
  wire        far_acc   = uses_mem && ((eff_addr < HSRAM_LO) || (eff_addr > HSRAM_HI));

  // ------------------------------------------------------------
  // Execution state
  // ------------------------------------------------------------
  reg  [3:0]  step;      // CPU cycle within the instruction.
  reg  [3:0]  last_step; // Final cycle of the instruction.
  reg  [3:0]  op_q;      // Latched operation.
  reg  [2:0]  kind_q;    // Latched bit operand kind.
  reg  [2:0]  bit_q;     // Latched bit number.
  reg  [1:0]  pair_q;    // Latched register pair.
  reg         loop_b_q;  // Loop register is B when set, else C.
  reg  [7:0]  disp_q;    // Latched displacement.
  reg  [15:0] addr_q;    // Latched memory operand address.
  reg  [2:0]  len_q;     // Latched instruction length.
  reg  [7:0]  opnd;      // Byte read from memory.

  wire [15:0] sext_disp = {{8{disp_q[7]}}, disp_q};
  wire [15:0] seq_pc    = PC + {13'h0000, len_q};
  wire [15:0] rel_pc    = seq_pc + sext_disp;
  wire [7:0]  bit_mask  = 8'h01 << bit_q;
  wire [7:0]  acc_byte  = REGS[8*`SBC_REG_A +: 8];
  wire [7:0]  loop_byte = loop_b_q ? REGS[8*`SBC_REG_B +: 8] : REGS[8*`SBC_REG_C +: 8];
  wire [7:0]  loop_dec  = loop_byte - 8'h01;
  wire [5:0]  lo_base   = {pair_q, 4'h0};  // Low byte of the pair: register 2*pair.
  wire [5:0]  hi_base   = {pair_q, 4'h8};  // High byte of the pair: register 2*pair+1.
  wire [5:0]  loop_base = loop_b_q ? 6'h18 : 6'h10;

  // Source byte for the bit test: accumulator, status word or memory.
  reg  [7:0]  test_byte;
  always @* begin
    case (kind_q)
      `SBC_KIND_ACC: test_byte = acc_byte;
      `SBC_KIND_PSW: test_byte = STATUS_WORD;
      default:       test_byte = opnd;
    endcase
  end
  wire        test_bit  = |(test_byte & bit_mask);
  wire        mem_opnd  = (kind_q == `SBC_KIND_SADDR) || (kind_q == `SBC_KIND_SFR) || (kind_q == `SBC_KIND_PTR);

  // Branch decision at the final cycle.
  reg         go;
  always @* begin
    case (op_q)
      `SBC_OP_JMP_REL:  go = 1'b1;
      `SBC_OP_JMP_CY:   go = STATUS_WORD[`SBC_PSW_CY];
      `SBC_OP_JMP_NCY:  go = ~STATUS_WORD[`SBC_PSW_CY];
      `SBC_OP_JMP_Z:    go = STATUS_WORD[`SBC_PSW_Z];
      `SBC_OP_JMP_NZ:   go = ~STATUS_WORD[`SBC_PSW_Z];
      `SBC_OP_BIT_SET, `SBC_OP_BIT_TCLR: go = test_bit;
      `SBC_OP_BIT_CLR:  go = ~test_bit;
      `SBC_OP_DJNZ_REG: go = (loop_dec != 8'h00);
      `SBC_OP_DJNZ_MEM: go = (opnd != 8'h00);
      default:          go = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Takes a request while idle, steps once per CPU tick, commits at the end.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
      TAKEN <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
      PC <= `SBC_PC_RESET;
      SP <= `SBC_SP_RESET;
      STATUS_WORD <= `SBC_PSW_RESET;
      REGS <= 64'h0000000000000000;
      step <= 4'h0;
      last_step <= 4'h0;
      op_q <= 4'h0;
      kind_q <= 3'h0;
      bit_q <= 3'h0;
      pair_q <= 2'h0;
      loop_b_q <= 1'b0;
      disp_q <= 8'h00;
      addr_q <= 16'h0000;
      len_q <= 3'h0;
      opnd <= 8'h00;
    end else begin
      DONE <= 1'b0;
      if (!BUSY) begin
        // Idle: state loads, then a new request.
        if (LOAD_EN) begin
          if (LOAD_SEL[3] == 1'b0) begin
            REGS[{LOAD_SEL[2:0], 3'b000} +: 8] <= LOAD_DATA;
          end else if (LOAD_SEL == `SBC_LOAD_PSW) begin
            STATUS_WORD <= LOAD_DATA;
          end else if (LOAD_SEL == `SBC_LOAD_SPL) begin
            SP[7:0] <= LOAD_DATA;
          end else if (LOAD_SEL == `SBC_LOAD_SPH) begin
            SP[15:8] <= LOAD_DATA;
          end else if (LOAD_SEL == `SBC_LOAD_PCL) begin
            PC[7:0] <= LOAD_DATA;
          end else if (LOAD_SEL == `SBC_LOAD_PCH) begin
            PC[15:8] <= LOAD_DATA;
          end
        end else if (START) begin
          BUSY <= 1'b1;
          TAKEN <= 1'b0;
          step <= 4'h0;
          last_step <= cyc_count(OP, KIND, far_acc) - 4'h1;
          op_q <= OP;
          kind_q <= KIND;
          bit_q <= BIT_SEL;
          pair_q <= PAIR_SEL;
          loop_b_q <= LOOP_SEL_B;
          disp_q <= REL_DISP8;
          addr_q <= eff_addr;
          len_q <= op_len(OP, KIND);
        end
      end else if (cpu_tick) begin
        // Strobes stand for one CPU cycle.
        MEM_RD <= 1'b0;
        MEM_WR <= 1'b0;
        step <= step + 4'h1;
        case (op_q)
          `SBC_OP_PUSH_RP: begin
            if (step == 4'h0) begin
              MEM_WR <= 1'b1;
              MEM_ADDR <= SP - 16'h0001;
              MEM_WDATA <= REGS[hi_base +: 8];
            end else if (step == 4'h1) begin
              MEM_WR <= 1'b1;
              MEM_ADDR <= SP - 16'h0002;
              MEM_WDATA <= REGS[lo_base +: 8];
            end
          end
          `SBC_OP_POP_PSW, `SBC_OP_POP_RP: begin
            if (step == 4'h0) begin
              MEM_RD <= 1'b1;
              MEM_ADDR <= SP;
            end else if (step == 4'h1 && op_q == `SBC_OP_POP_PSW) begin
              STATUS_WORD <= MEM_RDATA;
            end else if (step == 4'h1) begin
              opnd <= MEM_RDATA;
              MEM_RD <= 1'b1;
              MEM_ADDR <= SP + 16'h0001;
            end else if (step == 4'h2) begin
              REGS[lo_base +: 8] <= opnd;
              REGS[hi_base +: 8] <= MEM_RDATA;
            end
          end
          `SBC_OP_BIT_SET, `SBC_OP_BIT_CLR, `SBC_OP_BIT_TCLR, `SBC_OP_DJNZ_MEM: begin
            if (step == 4'h0 && (mem_opnd || op_q == `SBC_OP_DJNZ_MEM)) begin
              MEM_RD <= 1'b1;
              MEM_ADDR <= addr_q;
            end else if (step == 4'h1 && op_q == `SBC_OP_DJNZ_MEM) begin
              opnd <= MEM_RDATA - 8'h01;
            end else if (step == 4'h1 && mem_opnd) begin
              opnd <= MEM_RDATA;
            end else if (step == 4'h2 && op_q == `SBC_OP_DJNZ_MEM) begin
              MEM_WR <= 1'b1;
              MEM_WDATA <= opnd;
            end else if (step == 4'h2 && op_q == `SBC_OP_BIT_TCLR && mem_opnd && test_bit) begin
              MEM_WR <= 1'b1;
              MEM_WDATA <= opnd & ~bit_mask;
            end
          end
          default: begin
            // Register-only operations touch memory not at all.
          end
        endcase
        // Final cycle: program counter, pointers and flags.
        if (step == last_step) begin
          BUSY <= 1'b0;
          DONE <= 1'b1;
          TAKEN <= go;
          PC <= go ? rel_pc : seq_pc;
          case (op_q)
            `SBC_OP_PUSH_RP: SP <= SP - 16'h0002;
            `SBC_OP_POP_PSW: SP <= SP + 16'h0001;
            `SBC_OP_POP_RP:  SP <= SP + 16'h0002;
            `SBC_OP_JMP_ACC: PC <= {acc_byte, REGS[8*`SBC_REG_X +: 8]};
            `SBC_OP_INT_EN:  STATUS_WORD[`SBC_PSW_IE] <= 1'b1;
            `SBC_OP_INT_DIS: STATUS_WORD[`SBC_PSW_IE] <= 1'b0;
            `SBC_OP_DJNZ_REG: REGS[loop_base +: 8] <= loop_dec;
            `SBC_OP_BIT_TCLR: begin
              if (test_bit && kind_q == `SBC_KIND_PSW) begin
                STATUS_WORD <= STATUS_WORD & ~bit_mask;
              end else if (test_bit && kind_q == `SBC_KIND_ACC) begin
                REGS[8*`SBC_REG_A +: 8] <= acc_byte & ~bit_mask;
              end
            end
            default: begin
              // Other branches leave the flags as they are.
            end
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verification/sbc_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Byte memory on the far side of the memory port
// ------------------------------------------------------------
module sbc_mem_model (
  // Clock.
  input  wire logic        CLK,
  // Access strobes, address and write data.
  input  wire logic        MEM_RD,
  input  wire logic        MEM_WR,
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_WDATA,
  // Read data.
  output logic      [7:0]  MEM_RDATA
);
  reg   [7:0] mem [0:65535];  // Whole 64 KiB address space.
  logic [7:0] last = 8'h00;   // Last byte returned on a read.

  // Writes on every clock the strobe is high; back-to-back strobes merge into one level.
  always @(posedge CLK) begin
    if (MEM_WR) begin
      mem[MEM_ADDR] <= MEM_WDATA;
    end
    if (MEM_RD) begin
      last <= mem[MEM_ADDR];
    end
  end

  // Outside a read the bus shows the inverse of the last byte, so stale data never matches.
  assign MEM_RDATA = MEM_RD ? mem[MEM_ADDR] : ~last;
endmodule

`default_nettype wire

/* verification/sbc_exec_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sbc_exec_defs.vh"

// ------------------------------------------------------------
// Port checker for the execution block
// ------------------------------------------------------------
module sbc_exec_properties (
  // Clock, reset and clock selection.
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic [2:0]  CPU_CLOCK_CTRL_REG,
  // Request side.
  input wire logic        START,
  input wire logic [3:0]  OP,
  input wire logic [7:0]  REL_DISP8,
  input wire logic        LOAD_EN,
  // Observed outputs.
  input wire logic        MEM_WR,
  input wire logic [15:0] MEM_ADDR,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic        TAKEN,
  input wire logic [15:0] PC,
  input wire logic [15:0] SP,
  input wire logic [7:0]  STATUS_WORD
);
  reg [3:0]  op_q;  // Operation of the running instruction.
  reg [15:0] sp_q;  // Stack pointer before it.
  reg [15:0] pc_q;  // Program counter before it.
  reg [7:0]  sw_q;  // Status word before it.
  reg [7:0]  d_q;   // Its displacement.
  reg [7:0]  cnt;   // Clocks spent busy.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // Captures the state seen when a request is taken, then counts busy clocks.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op_q <= 4'h0;
      sp_q <= 16'h0000;
      pc_q <= 16'h0000;
      sw_q <= 8'h00;
      d_q  <= 8'h00;
      cnt  <= 8'h00;
    end else if (START && !BUSY && !LOAD_EN) begin
      op_q <= OP;
      sp_q <= SP;
      pc_q <= PC;
      sw_q <= STATUS_WORD;
      d_q  <= REL_DISP8;
      cnt  <= 8'h00;
    end else if (BUSY) begin
      cnt <= cnt + 8'h01;
    end
  end

  a_done_ends_busy: assert property (DONE |-> $fell(BUSY))
    else $error("done without busy falling");
  a_done_one_pulse: assert property (DONE |=> !DONE)
    else $error("done longer than one clock");
  a_push_sp_down: assert property (DONE && op_q == `SBC_OP_PUSH_RP |-> SP == sp_q - 16'h0002)
    else $error("push left wrong stack pointer");
  a_push_write_addr: assert property (MEM_WR && op_q == `SBC_OP_PUSH_RP |->
    MEM_ADDR == sp_q - 16'h0001 || MEM_ADDR == sp_q - 16'h0002)
    else $error("push wrote outside its two slots");
  a_pop_status_sp: assert property (DONE && op_q == `SBC_OP_POP_PSW |-> SP == sp_q + 16'h0001)
    else $error("status pop left wrong stack pointer");
  a_pop_pair_sp: assert property (DONE && op_q == `SBC_OP_POP_RP |-> SP == sp_q + 16'h0002)
    else $error("pair pop left wrong stack pointer");
  a_rel_jump_pc: assert property (DONE && op_q == `SBC_OP_JMP_REL |->
    PC == pc_q + 16'h0002 + {{8{d_q[7]}}, d_q})
    else $error("relative jump target wrong");
  a_rel_jump_time: assert property (DONE && op_q == `SBC_OP_JMP_REL && CPU_CLOCK_CTRL_REG == 3'h0 |->
    cnt inside {8'd6, 8'd7})
    else $error("relative jump duration wrong");
  a_carry_decide: assert property (DONE && op_q == `SBC_OP_JMP_CY |-> TAKEN == sw_q[0])
    else $error("carry branch decision wrong");
  a_zero_decide: assert property (DONE && op_q == `SBC_OP_JMP_Z |-> TAKEN == sw_q[6])
    else $error("zero branch decision wrong");
  a_flags_kept: assert property (DONE && op_q inside {[4'h3:4'ha], 4'hc, 4'hd} |->
    (STATUS_WORD & 8'h51) == (sw_q & 8'h51))
    else $error("branch changed the flags");
  a_int_on: assert property (DONE && op_q == `SBC_OP_INT_EN |-> STATUS_WORD[7])
    else $error("interrupt enable not set");
  a_int_off: assert property (DONE && op_q == `SBC_OP_INT_DIS |-> !STATUS_WORD[7])
    else $error("interrupt enable not cleared");
endmodule

`default_nettype wire

/* verification/tb_stack_branch_cpu_control_exec.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sbc_exec_defs.vh"

// ------------------------------------------------------------
// Self-checking bench for the execution block
// ------------------------------------------------------------
module tb_stack_branch_cpu_control_exec;
  logic        CLK, ARST_N, START, LOOP_SEL_B, LOAD_EN, MEM_RD, MEM_WR, BUSY, DONE, TAKEN;
  logic [2:0]  CPU_CLOCK_CTRL_REG, KIND, BIT_SEL;
  logic [3:0]  OP, LOAD_SEL;
  logic [1:0]  PAIR_SEL;
  logic [7:0]  REL_DISP8, LOAD_DATA, MEM_WDATA, MEM_RDATA, STATUS_WORD;
  logic [15:0] OPND_ADDR, MEM_ADDR, PC, SP, epc;
  logic [63:0] REGS;
  int          num_errors = 0, compares = 0, cyc, off = -1;

  sbc_exec u_dut (.CLK(CLK), .ARST_N(ARST_N), .CPU_CLOCK_CTRL_REG(CPU_CLOCK_CTRL_REG), .START(START),
    .OP(OP), .KIND(KIND), .BIT_SEL(BIT_SEL), .PAIR_SEL(PAIR_SEL), .LOOP_SEL_B(LOOP_SEL_B),
    .REL_DISP8(REL_DISP8), .OPND_ADDR(OPND_ADDR), .LOAD_EN(LOAD_EN), .LOAD_SEL(LOAD_SEL),
    .LOAD_DATA(LOAD_DATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .DONE(DONE), .TAKEN(TAKEN), .PC(PC), .SP(SP),
    .STATUS_WORD(STATUS_WORD), .REGS(REGS));
  sbc_mem_model u_mem (.CLK(CLK), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));

  // Free-running 100 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Compares one value and counts it.
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Writes one byte of state through the idle load port.
  task ld(input [3:0] s, input [7:0] d);
    @(negedge CLK); LOAD_EN = 1'b1; LOAD_SEL = s; LOAD_DATA = d;
    @(negedge CLK); LOAD_EN = 1'b0;
  endtask

  task setpc(input [15:0] v);
    ld(`SBC_LOAD_PCL, v[7:0]);
    ld(`SBC_LOAD_PCH, v[15:8]);
    epc = v;
  endtask

  // Issues one instruction and counts clocks until its completion pulse.
  task go(input [3:0] op, input [2:0] k, input [2:0] b, input [15:0] a);
    @(negedge CLK); START = 1'b1; OP = op; KIND = k; BIT_SEL = b; OPND_ADDR = a;
    @(negedge CLK); START = 1'b0; cyc = 0;
    while (DONE !== 1'b1 && cyc < 300) begin
      @(negedge CLK); cyc++;
    end
    if (cyc >= 300) chk("done", 16'h0000, 16'h0001);
  endtask

  // Runs one instruction and judges decision, next address and duration.
  task ex(input [3:0] op, input [2:0] k, input [2:0] b, input [15:0] a, input tk, input [2:0] len,
          input [3:0] n);
    go(op, k, b, a);
    epc = epc + len + (tk ? {{8{REL_DISP8[7]}}, REL_DISP8} : 16'h0000);
    chk("taken", TAKEN, tk);
    chk("pc", PC, epc);
    if (off < 0) off = cyc - n;
    chk("cycles", 16'(cyc - n), 16'(off));
  endtask

  task t_stack;
    ld(`SBC_LOAD_SPL, 8'h00); ld(`SBC_LOAD_SPH, 8'h10); ld(4'h2, 8'h12); ld(4'h3, 8'h34);
    setpc(16'h0100);
    PAIR_SEL = 2'd1;
    ex(`SBC_OP_PUSH_RP, 3'h0, 3'h0, 16'h0000, 1'b0, 3'd1, 4'd4);
    chk("push high", u_mem.mem[16'h0fff], 16'h0034);
    chk("push low", u_mem.mem[16'h0ffe], 16'h0012);
    PAIR_SEL = 2'd3;
    ex(`SBC_OP_POP_RP, 3'h0, 3'h0, 16'h0000, 1'b0, 3'd1, 4'd4);
    chk("pair", REGS[63:48], 16'h3412);
    u_mem.mem[16'h1000] = 8'h51;
    ex(`SBC_OP_POP_PSW, 3'h0, 3'h0, 16'h0000, 1'b0, 3'd1, 4'd2);
    chk("flags", STATUS_WORD & 8'h51, 16'h0051);
    chk("sp", SP, 16'h1001);
    $display("stack test done");
  endtask

  task t_jump;
    REL_DISP8 = 8'hf0; setpc(16'h2000);
    ex(`SBC_OP_JMP_REL, 3'h0, 3'h0, 16'h0000, 1'b1, 3'd2, 4'd6);
    ld(4'h1, 8'h3c); ld(4'h0, 8'h5a);
    go(`SBC_OP_JMP_ACC, 3'h0, 3'h0, 16'h0000); epc = 16'h3c5a;
    chk("pc", PC, epc);
    chk("cycles", 16'(cyc - 8), 16'(off));
    for (int i = 0; i < 2; i++) begin
      ld(`SBC_LOAD_PSW, i ? 8'h41 : 8'h10);
      ex(`SBC_OP_JMP_CY, 3'h0, 3'h0, 16'h0000, i == 1, 3'd2, 4'd6);
      ex(`SBC_OP_JMP_NCY, 3'h0, 3'h0, 16'h0000, i == 0, 3'd2, 4'd6);
      ex(`SBC_OP_JMP_Z, 3'h0, 3'h0, 16'h0000, i == 1, 3'd2, 4'd6);
      ex(`SBC_OP_JMP_NZ, 3'h0, 3'h0, 16'h0000, i == 0, 3'd2, 4'd6);
      chk("flags", STATUS_WORD & 8'h51, i ? 16'h0041 : 16'h0010);
    end
    $display("jump test done");
  endtask

  task t_bits;
    REL_DISP8 = 8'h20; setpc(16'h0300);
    u_mem.mem[16'hfb10] = 8'h08; u_mem.mem[16'h0040] = 8'h08;
    ex(`SBC_OP_BIT_SET, `SBC_KIND_SADDR, 3'd3, 16'hfb10, 1'b1, 3'd3, 4'd8);
    ex(`SBC_OP_BIT_SET, `SBC_KIND_SADDR, 3'd3, 16'h0040, 1'b1, 3'd3, 4'd9);
    ex(`SBC_OP_BIT_SET, `SBC_KIND_SADDR, 3'd2, 16'hfb10, 1'b0, 3'd3, 4'd8);
    ex(`SBC_OP_BIT_SET, `SBC_KIND_SFR, 3'd3, 16'h0040, 1'b1, 3'd4, 4'd11);
    ex(`SBC_OP_BIT_CLR, `SBC_KIND_SADDR, 3'd3, 16'h0040, 1'b0, 3'd4, 4'd11);
    ex(`SBC_OP_BIT_CLR, `SBC_KIND_SADDR, 3'd2, 16'hfb10, 1'b1, 3'd4, 4'd10);
    ld(4'h6, 8'h10); ld(4'h7, 8'hfb); ld(4'h1, 8'h04);
    ex(`SBC_OP_BIT_CLR, `SBC_KIND_PTR, 3'd4, 16'h0000, 1'b1, 3'd3, 4'd10);
    ex(`SBC_OP_BIT_SET, `SBC_KIND_ACC, 3'd2, 16'h0000, 1'b1, 3'd3, 4'd8);
    ex(`SBC_OP_BIT_TCLR, `SBC_KIND_SADDR, 3'd3, 16'h0040, 1'b1, 3'd4, 4'd12);
    chk("cleared", u_mem.mem[16'h0040], 16'h0000);
    ex(`SBC_OP_BIT_TCLR, `SBC_KIND_SADDR, 3'd3, 16'h0040, 1'b0, 3'd4, 4'd12);
    ex(`SBC_OP_BIT_TCLR, `SBC_KIND_PTR, 3'd3, 16'h0000, 1'b1, 3'd3, 4'd10);
    chk("cleared", u_mem.mem[16'hfb10], 16'h0000);
    ex(`SBC_OP_BIT_TCLR, `SBC_KIND_ACC, 3'd2, 16'h0000, 1'b1, 3'd3, 4'd8);
    chk("acc", REGS[15:8], 16'h0000);
    ld(`SBC_LOAD_PSW, 8'h01);
    ex(`SBC_OP_BIT_SET, `SBC_KIND_PSW, 3'd0, 16'h0000, 1'b1, 3'd3, 4'd9);
    ex(`SBC_OP_BIT_TCLR, `SBC_KIND_PSW, 3'd0, 16'h0000, 1'b1, 3'd4, 4'd12);
    chk("carry", STATUS_WORD[0], 16'h0000);
    $display("bit test done");
  endtask

  task t_loop;
    REL_DISP8 = 8'hfe; setpc(16'h0500); ld(4'h2, 8'h02); ld(4'h3, 8'h00);
    LOOP_SEL_B = 1'b0;
    ex(`SBC_OP_DJNZ_REG, 3'h0, 3'h0, 16'h0000, 1'b1, 3'd2, 4'd6);
    ex(`SBC_OP_DJNZ_REG, 3'h0, 3'h0, 16'h0000, 1'b0, 3'd2, 4'd6);
    chk("loop c", REGS[23:16], 16'h0000);
    LOOP_SEL_B = 1'b1;
    ex(`SBC_OP_DJNZ_REG, 3'h0, 3'h0, 16'h0000, 1'b1, 3'd2, 4'd6);
    chk("loop b", REGS[31:24], 16'h00ff);
    u_mem.mem[16'hfb20] = 8'h01; u_mem.mem[16'h0050] = 8'h05;
    ex(`SBC_OP_DJNZ_MEM, 3'h0, 3'h0, 16'hfb20, 1'b0, 3'd3, 4'd8);
    chk("mem", u_mem.mem[16'hfb20], 16'h0000);
    ex(`SBC_OP_DJNZ_MEM, 3'h0, 3'h0, 16'h0050, 1'b1, 3'd3, 4'd10);
    chk("mem", u_mem.mem[16'h0050], 16'h0004);
    $display("loop test done");
  endtask

  task t_ctrl;
    setpc(16'h0600);
    ex(`SBC_OP_INT_EN, 3'h0, 3'h0, 16'h0000, 1'b0, 3'd2, 4'd6);
    chk("ie", STATUS_WORD[7], 16'h0001);
    ex(`SBC_OP_INT_DIS, 3'h0, 3'h0, 16'h0000, 1'b0, 3'd2, 4'd6);
    chk("ie", STATUS_WORD[7], 16'h0000);
    CPU_CLOCK_CTRL_REG = 3'd1; REL_DISP8 = 8'h04;
    go(`SBC_OP_JMP_REL, 3'h0, 3'h0, 16'h0000); epc = epc + 16'h0006;
    chk("pc", PC, epc);
    chk("slow", 16'(cyc - off >= 11 && cyc - off <= 12), 16'h0001);
    @(negedge CLK);
    CPU_CLOCK_CTRL_REG = 3'd0;
    $display("control test done");
  endtask

  task final_report;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: reset for 20 clocks, then every scenario.
  initial begin
    ARST_N = 1'b0; START = 1'b0; LOOP_SEL_B = 1'b0; LOAD_EN = 1'b0; CPU_CLOCK_CTRL_REG = 3'd0;
    KIND = 3'd0; BIT_SEL = 3'd0; OP = 4'h0; LOAD_SEL = 4'h0; PAIR_SEL = 2'd0; REL_DISP8 = 8'h00;
    LOAD_DATA = 8'h00; OPND_ADDR = 16'h0000; epc = 16'h0000;
    repeat (20) @(negedge CLK);
    ARST_N = 1'b1;
    repeat (3) @(negedge CLK);
    t_stack; t_jump; t_bits; t_loop; t_ctrl;
    final_report;
  end

  // Watchdog sized well above the few hundred clocks the scenarios need.
  initial begin
    #300000;
    num_errors++;
    $display("watchdog expired");
    final_report;
  end
endmodule

bind sbc_exec sbc_exec_properties u_props (.CLK(CLK), .ARST_N(ARST_N), .CPU_CLOCK_CTRL_REG(CPU_CLOCK_CTRL_REG),
  .START(START), .OP(OP), .REL_DISP8(REL_DISP8), .LOAD_EN(LOAD_EN), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
  .BUSY(BUSY), .DONE(DONE), .TAKEN(TAKEN), .PC(PC), .SP(SP), .STATUS_WORD(STATUS_WORD));

`default_nettype wire
